// [logic/isa_ext_pkg.sv]
package isa_ext_pkg;
	localparam int DATA_W = 32;
	localparam int ACC_W = 64;
	localparam int REG_ADDR_W = 5;
	localparam int COUNT_W = 6;
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_SECOND_GROUP = 6'h1C;
	localparam logic [5:0] FN_MOVE_IF_ZERO = 6'h0A;
	localparam logic [5:0] FN_MOVE_IF_NONZERO = 6'h0B;
	localparam logic [5:0] FN_SIGNED_MUL_ACC = 6'h00;
	localparam logic [5:0] FN_UNSIGNED_MUL_ACC = 6'h01;
	localparam logic [5:0] FN_SIGNED_MUL_SUB = 6'h04;
	localparam logic [5:0] FN_UNSIGNED_MUL_SUB = 6'h05;
	localparam logic [5:0] FN_LEAD_ZERO = 6'h20;
	localparam logic [5:0] FN_LEAD_ONE = 6'h21;
	localparam logic [4:0] SHAMT_ZERO = 5'h00;
	localparam int OP_LSB = 26;
	localparam int RS_LSB = 21;
	localparam int RT_LSB = 16;
	localparam int RD_LSB = 11;
	localparam int SH_LSB = 6;
	localparam int MAC_LATENCY = 2;
	typedef enum logic [2:0] {
		MAC_S_ADD,
		MAC_U_ADD,
		MAC_S_SUB,
		MAC_U_SUB
	} mac_kind_t;
endpackage

// [logic/isa_extension_datapath.sv]
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Any instruction asking for 64-bit data, coprocessor moves too, traps in every mode.
// RULE2 - Move-if-nonzero copies first source to destination when second source is nonzero.
// RULE3 - Move-if-zero copies first source to destination when second source is zero.
// RULE4 - Signed multiply-accumulate adds 64-bit product to accumulator, no overflow.
// RULE5 - Unsigned multiply-accumulate adds 64-bit product to accumulator, no overflow.
// RULE6 - Signed multiply-subtract takes 64-bit product from accumulator, no overflow.
// RULE7 - Unsigned multiply-subtract takes 64-bit product from accumulator, no overflow.
// RULE8 - Result bits 31..0 go to lower word, bits 63..32 to upper word.
// RULE9 - Accumulator is not interlocked; reads before completion may be undefined.
// RULE10 - Count leading zeros of first source into second source register, 32 for zero.
// RULE11 - Count leading ones of first source into second source register, 32 for all ones.
// RULE12 - Unassigned second-group function codes raise a reserved-instruction exception.
// RULE13 - A 64-bit trap leaves accumulator and register file unchanged.
module isa_extension_datapath
	import isa_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic issue_valid,
	input wire logic [DATA_W-1:0] instr,
	input wire logic wide_data_request,
	input wire logic [DATA_W-1:0] first_source_reg,
	input wire logic [DATA_W-1:0] second_source_reg,
	output logic reg_write_en,
	output logic [REG_ADDR_W-1:0] reg_write_addr,
	output logic [DATA_W-1:0] reg_write_data,
	output logic [DATA_W-1:0] accumulator_upper_word,
	output logic [DATA_W-1:0] accumulator_lower_word,
	output logic acc_busy,
	output logic wide_trap,
	output logic reserved_instr,
	output logic handled
);
	typedef struct packed {
		logic wr_en;
		logic [REG_ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
		logic [ACC_W-1:0] acc;
		logic pending;
		logic trap;
		logic resv;
		logic handled;
	} dp_state_t;
	dp_state_t state_reg, state_next;
	mac_if mbus ();
	logic [5:0] opcode, funct;
	logic [4:0] rs_f, rt_f, rd_f, sh_f;
	logic is_special, is_group2, is_move_if_zero, is_move_if_nonzero, is_mac, is_clz, is_clo;
	logic [COUNT_W-1:0] lead_count;
	mac_kind_t mac_kind;

	assign opcode = instr[OP_LSB +: 6];
	assign rs_f = instr[RS_LSB +: 5];
	assign rt_f = instr[RT_LSB +: 5];
	assign rd_f = instr[RD_LSB +: 5];
	assign sh_f = instr[SH_LSB +: 5];
	assign funct = instr[5:0];
	assign is_special = issue_valid && !wide_data_request && opcode == OP_SPECIAL;
	assign is_group2 = issue_valid && !wide_data_request && opcode == OP_SECOND_GROUP;
	assign is_move_if_nonzero = is_special && funct == FN_MOVE_IF_NONZERO && sh_f == SHAMT_ZERO; // RULE2
	assign is_move_if_zero = is_special && funct == FN_MOVE_IF_ZERO; // RULE3
	assign is_clz = is_group2 && funct == FN_LEAD_ZERO; // RULE10
	assign is_clo = is_group2 && funct == FN_LEAD_ONE; // RULE11
	assign is_mac = is_group2 && (funct == FN_SIGNED_MUL_ACC || funct == FN_UNSIGNED_MUL_ACC
		|| funct == FN_SIGNED_MUL_SUB || funct == FN_UNSIGNED_MUL_SUB);

	always_comb begin
		case (funct)
			FN_SIGNED_MUL_ACC: mac_kind = MAC_S_ADD;
			FN_UNSIGNED_MUL_ACC: mac_kind = MAC_U_ADD;
			FN_SIGNED_MUL_SUB: mac_kind = MAC_S_SUB;
			default: mac_kind = MAC_U_SUB;
		endcase
	end

	leading_count #(.WIDTH(DATA_W)) u_lead (
		.value(first_source_reg),
		.count_ones(is_clo),
		.count(lead_count)
	);

	assign mbus.start = is_mac;
	assign mbus.kind = mac_kind;
	assign mbus.a = first_source_reg;
	assign mbus.b = second_source_reg;
	// A result landing this cycle is forwarded, so an accumulate two cycles behind the last sees it
	// Back-to-back accumulates are still not allowed: the second would cancel the first
	assign mbus.acc_in = mbus.done ? mbus.acc_out : state_reg.acc;

	mac_unit u_mac (
		.ref_clk(ref_clk),
		.rst(rst),
		.m(mbus)
	);

	always_comb begin
		state_next = state_reg;
		state_next.wr_en = 1'b0;
		state_next.trap = 1'b0;
		state_next.resv = 1'b0;
		state_next.handled = 1'b0;
		if (mbus.done) begin
			state_next.acc = mbus.acc_out; // RULE8
			state_next.pending = 1'b0;
		end
		if (issue_valid && wide_data_request) begin
			// Nothing else is written on a trap
			state_next.trap = 1'b1; // RULE1 RULE13
		end else if (is_move_if_nonzero || is_move_if_zero) begin
			state_next.handled = 1'b1;
			state_next.wr_en = is_move_if_nonzero ? second_source_reg != '0 : second_source_reg == '0; // RULE2 RULE3
			state_next.wr_addr = rd_f;
			state_next.wr_data = first_source_reg;
		end else if (is_clz || is_clo) begin
			state_next.handled = 1'b1;
			state_next.wr_en = 1'b1; // RULE10 RULE11
			state_next.wr_addr = rt_f;
			state_next.wr_data = DATA_W'(lead_count);
		end else if (is_mac) begin
			state_next.handled = 1'b1;
			state_next.pending = 1'b1; // RULE9
		end else if (is_group2) begin
			state_next.resv = 1'b1; // RULE12
		end
		if (rst) begin
			state_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign reg_write_en = state_reg.wr_en;
	assign reg_write_addr = state_reg.wr_addr;
	assign reg_write_data = state_reg.wr_data;
	assign accumulator_upper_word = state_reg.acc[ACC_W-1:DATA_W]; // RULE8
	assign accumulator_lower_word = state_reg.acc[DATA_W-1:0]; // RULE8
	assign acc_busy = state_reg.pending;
	assign wide_trap = state_reg.trap;
	assign reserved_instr = state_reg.resv;
	assign handled = state_reg.handled;

	a_trap_no_write: assert property (@(posedge ref_clk) disable iff (rst)
		issue_valid && wide_data_request |=> wide_trap && !reg_write_en && !handled) // RULE13
		else $error("trap let a write through");
	a_trap_raised: assert property (@(posedge ref_clk) disable iff (rst)
		issue_valid && wide_data_request |=> wide_trap) // RULE1
		else $error("no trap on wide request");
	a_move_if_nonzero_write: assert property (@(posedge ref_clk) disable iff (rst)
		is_move_if_nonzero |=> reg_write_en == ($past(second_source_reg) != 0) && reg_write_data == $past(first_source_reg)) // RULE2
		else $error("move-if-nonzero wrong");
	a_move_if_zero_write: assert property (@(posedge ref_clk) disable iff (rst)
		is_move_if_zero |=> reg_write_en == ($past(second_source_reg) == 0) && reg_write_addr == $past(rd_f)) // RULE3
		else $error("move-if-zero wrong");
	a_clz_zero: assert property (@(posedge ref_clk) disable iff (rst)
		is_clz && first_source_reg == 0 |=> reg_write_en && reg_write_data == 32'h00000020) // RULE10
		else $error("leading zero count of zero not 32");
	a_clo_ones: assert property (@(posedge ref_clk) disable iff (rst)
		is_clo && first_source_reg == 32'hFFFFFFFF |=> reg_write_data == 32'h00000020) // RULE11
		else $error("leading one count of all ones not 32");

	// The accumulator words show the new value three edges after the issuing edge
	a_mac_signed: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac && funct == FN_SIGNED_MUL_ACC && !acc_busy |-> ##3
		{accumulator_upper_word, accumulator_lower_word} == $past(state_reg.acc, 3)
		+ 64'($signed($past(first_source_reg, 3))) * 64'($signed($past(second_source_reg, 3)))) // RULE4
		else $error("signed accumulate wrong");

	a_mac_uadd: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac && funct == FN_UNSIGNED_MUL_ACC && !acc_busy |-> ##3
		{accumulator_upper_word, accumulator_lower_word} == $past(state_reg.acc, 3)
		+ {32'h0, $past(first_source_reg, 3)} * {32'h0, $past(second_source_reg, 3)}) // RULE5
		else $error("unsigned accumulate wrong");

	a_mac_ssub: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac && funct == FN_SIGNED_MUL_SUB && !acc_busy |-> ##3
		{accumulator_upper_word, accumulator_lower_word} == $past(state_reg.acc, 3)
		- 64'($signed($past(first_source_reg, 3))) * 64'($signed($past(second_source_reg, 3)))) // RULE6
		else $error("signed subtract wrong");

	a_mac_usub: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac && funct == FN_UNSIGNED_MUL_SUB && !acc_busy |-> ##3
		{accumulator_upper_word, accumulator_lower_word} == $past(state_reg.acc, 3)
		- {32'h0, $past(first_source_reg, 3)} * {32'h0, $past(second_source_reg, 3)}) // RULE7
		else $error("unsigned subtract wrong");

	a_mac_start: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac |=> handled && acc_busy && !reg_write_en) // RULE4
		else $error("accumulate not started");

	a_acc_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!mbus.done |=> $stable({accumulator_upper_word, accumulator_lower_word})) // RULE8
		else $error("accumulator moved without a result");

	a_resv_unassigned: assert property (@(posedge ref_clk) disable iff (rst)
		is_group2 && !is_mac && !is_clz && !is_clo |=> reserved_instr) // RULE12
		else $error("no reserved exception");

	a_resv_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		!is_group2 |=> !reserved_instr) // RULE12
		else $error("reserved exception without cause");

	// A new accumulate may land on the completing edge; it then keeps busy up
	a_busy_bound: assert property (@(posedge ref_clk) disable iff (rst)
		is_mac |=> acc_busy ##1 acc_busy ##1 (!acc_busy || $past(is_mac))) // RULE9
		else $error("accumulate not done in time");

	a_trap_only_issue: assert property (@(posedge ref_clk) disable iff (rst)
		!(issue_valid && wide_data_request) |=> !wide_trap) // RULE1
		else $error("trap without wide request");

	a_trap_acc_kept: assert property (@(posedge ref_clk) disable iff (rst)
		issue_valid && wide_data_request && !acc_busy |=> $stable({accumulator_upper_word, accumulator_lower_word})) // RULE13
		else $error("trap changed the accumulator");

	a_move_if_nonzero_addr: assert property (@(posedge ref_clk) disable iff (rst)
		is_move_if_nonzero |=> reg_write_addr == $past(rd_f) && handled) // RULE2
		else $error("move-if-nonzero address wrong");

	a_move_if_zero_data: assert property (@(posedge ref_clk) disable iff (rst)
		is_move_if_zero |=> reg_write_data == $past(first_source_reg) && handled) // RULE3
		else $error("move-if-zero data wrong");

	a_clz_top: assert property (@(posedge ref_clk) disable iff (rst)
		is_clz && first_source_reg[DATA_W-1] |=> reg_write_en && reg_write_data == '0) // RULE10
		else $error("leading zero count of set top bit not 0");

	a_clo_top: assert property (@(posedge ref_clk) disable iff (rst)
		is_clo && !first_source_reg[DATA_W-1] |=> reg_write_en && reg_write_data == '0) // RULE11
		else $error("leading one count of clear top bit not 0");

	a_count_addr: assert property (@(posedge ref_clk) disable iff (rst)
		is_clz || is_clo |=> reg_write_addr == $past(rt_f)) // RULE10
		else $error("count written to wrong register");

	c_mac: cover property (@(posedge ref_clk) disable iff (rst) is_mac ##3 !acc_busy);
	c_mac_close: cover property (@(posedge ref_clk) disable iff (rst) is_mac ##2 is_mac);
	c_move_if_nonzero_skip: cover property (@(posedge ref_clk) disable iff (rst) is_move_if_nonzero && second_source_reg == 0);
	c_trap: cover property (@(posedge ref_clk) disable iff (rst) wide_trap);
	c_clo: cover property (@(posedge ref_clk) disable iff (rst) is_clo);
endmodule

// [logic/leading_count.sv]
`timescale 1ns/1ps
module leading_count
	import isa_ext_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input wire logic [WIDTH-1:0] value,
	input wire logic count_ones,
	output logic [COUNT_W-1:0] count
);
	logic [WIDTH-1:0] probe;
	logic [WIDTH:0] run;
	assign probe = count_ones ? ~value : value;
	assign run[WIDTH] = 1'b1;
	genvar i;
	generate
		// Ascending loop keeps the genvar non-negative; the chain still runs from the top bit down
		for (i = 0; i < WIDTH; i++) begin : g_scan
			assign run[i] = run[i+1] & ~probe[i];
		end
	endgenerate
	always_comb begin
		count = '0;
		for (int k = 0; k < WIDTH; k++) begin
			count = count + COUNT_W'(run[k]);
		end
	end
endmodule

// [logic/mac_if.sv]
`timescale 1ns/1ps
interface mac_if;
	import isa_ext_pkg::*;
	logic start;
	mac_kind_t kind;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] b;
	logic [ACC_W-1:0] acc_in;
	logic done;
	logic [ACC_W-1:0] acc_out;
	modport ctrl (output start, output kind, output a, output b, output acc_in, input done, input acc_out);
	modport unit (input start, input kind, input a, input b, input acc_in, output done, output acc_out);
endinterface

// [logic/mac_unit.sv]
`timescale 1ns/1ps
module mac_unit
	import isa_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	mac_if.unit m
);
	typedef struct packed {
		logic busy;
		logic done;
		logic sub;
		logic [ACC_W-1:0] prod;
		logic [ACC_W-1:0] acc;
		logic [ACC_W-1:0] res;
	} mac_state_t;
	mac_state_t state_reg, state_next;
	logic [ACC_W-1:0] sprod, uprod;
	// Operands widened first so the upper product half is never lost
	assign sprod = ACC_W'($signed(m.a)) * ACC_W'($signed(m.b));
	assign uprod = ACC_W'({32'h0, m.a} * {32'h0, m.b});
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (m.start) begin
			state_next.busy = 1'b1;
			state_next.acc = m.acc_in;
			state_next.sub = (m.kind == MAC_S_SUB) || (m.kind == MAC_U_SUB);
			state_next.prod = (m.kind == MAC_S_ADD || m.kind == MAC_S_SUB) ? sprod : uprod; // RULE4 RULE5 RULE6 RULE7
		end else if (state_reg.busy) begin
			state_next.busy = 1'b0;
			state_next.done = 1'b1;
			// Wraps modulo 2^64; no overflow signal exists
			state_next.res = state_reg.sub ? state_reg.acc - state_reg.prod : state_reg.acc + state_reg.prod; // RULE4 RULE6
		end
		if (rst) begin
			state_next = '0;
		end
	end
	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end
	assign m.done = state_reg.done;
	assign m.acc_out = state_reg.res;
endmodule

// [testbench/regfile_model.sv]
`timescale 1ns/1ps
module regfile_model
	import isa_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic write_en,
	input wire logic [REG_ADDR_W-1:0] write_addr,
	input wire logic [DATA_W-1:0] write_data
);
	// Preloaded so a stray write shows as a changed entry
	logic [DATA_W-1:0] mem [32];
	initial begin
		for (int i = 0; i < 32; i++) begin
			mem[i] = 32'hA5A5_0000 | 32'(i);
		end
	end
	always @(posedge ref_clk) begin
		if (write_en) begin
			mem[write_addr] <= write_data;
		end
	end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import isa_ext_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic issue_valid = 1'b0;
	logic [DATA_W-1:0] instr = '0;
	logic wide_data_request = 1'b0;
	logic [DATA_W-1:0] first_source_reg = '0;
	logic [DATA_W-1:0] second_source_reg = '0;
	logic we, busy, trap, rsv, hnd;
	logic [REG_ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd, hi, lo;
	logic [ACC_W-1:0] acc_exp = '0;
	int err_count = 0;
	int cmp_count = 0;
	isa_extension_datapath DUT (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
		.wide_data_request(wide_data_request), .first_source_reg(first_source_reg),
		.second_source_reg(second_source_reg), .reg_write_en(we), .reg_write_addr(wa), .reg_write_data(wd),
		.accumulator_upper_word(hi), .accumulator_lower_word(lo), .acc_busy(busy), .wide_trap(trap),
		.reserved_instr(rsv), .handled(hnd));
	regfile_model rf (.ref_clk(ref_clk), .write_en(we), .write_addr(wa), .write_data(wd));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [DATA_W-1:0] enc(logic [5:0] op, logic [4:0] d, logic [4:0] sh, logic [5:0] fn);
		return {op, 5'h01, 5'h02, d, sh, fn};
	endfunction
	// Outputs of the taking edge are settled when this returns
	task automatic issue(input logic [DATA_W-1:0] w, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
		input logic wide);
		@(negedge ref_clk);
		instr = w;
		first_source_reg = a;
		second_source_reg = b;
		wide_data_request = wide;
		issue_valid = 1'b1;
		@(negedge ref_clk);
		issue_valid = 1'b0;
		wide_data_request = 1'b0;
	endtask
	task automatic test_moves();
		issue(enc(OP_SPECIAL, 5'h03, SHAMT_ZERO, FN_MOVE_IF_NONZERO), 32'h1234_5678, 32'h0000_0100, 1'b0);
		chk({we, wa, wd, hnd}, {1'b1, 5'h03, 32'h1234_5678, 1'b1});
		issue(enc(OP_SPECIAL, 5'h04, SHAMT_ZERO, FN_MOVE_IF_NONZERO), 32'hCAFE_0001, 32'h0, 1'b0);
		chk({we, hnd}, 2'h1);
		issue(enc(OP_SPECIAL, 5'h04, 5'h01, FN_MOVE_IF_NONZERO), 32'hCAFE_0001, 32'h1, 1'b0);
		chk({we, hnd}, 2'h0);
		issue(enc(OP_SPECIAL, 5'h05, SHAMT_ZERO, FN_MOVE_IF_ZERO), 32'h8765_4321, 32'h0, 1'b0);
		chk({we, wa, wd}, {1'b1, 5'h05, 32'h8765_4321});
		issue(enc(OP_SPECIAL, 5'h06, SHAMT_ZERO, FN_MOVE_IF_ZERO), 32'h8765_4321, 32'h8000_0000, 1'b0);
		chk({we, hnd}, 2'h1);
		chk(rf.mem[6], 32'hA5A5_0006);
	endtask
	task automatic mac_op(input logic [5:0] fn, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		logic [ACC_W-1:0] p;
		p = fn[0] ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b};
		acc_exp = fn[2] ? acc_exp - p : acc_exp + p;
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, fn), a, b, 1'b0);
		chk({busy, hnd, we, trap}, 4'hC);
		// The accumulator is not interlocked, so it is read only once busy drops
		for (int k = 0; k < 8 && busy !== 1'b0; k++) begin
			@(negedge ref_clk);
		end
		chk({hi, lo}, acc_exp);
	endtask
	task automatic test_mac();
		mac_op(FN_SIGNED_MUL_ACC, 32'hFFFF_FFFD, 32'h0000_0007);
		mac_op(FN_UNSIGNED_MUL_ACC, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		mac_op(FN_SIGNED_MUL_SUB, 32'h8000_0000, 32'h7FFF_FFFF);
		mac_op(FN_UNSIGNED_MUL_SUB, 32'hFFFF_0000, 32'h0001_0003);
		// Closest legal spacing: the second accumulate is taken two cycles after the first
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, FN_UNSIGNED_MUL_ACC), 32'h3, 32'h5, 1'b0);
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, FN_UNSIGNED_MUL_ACC), 32'h2, 32'h4, 1'b0);
		repeat (3) @(negedge ref_clk);
		acc_exp = acc_exp + 64'h17;
		chk({hi, lo}, acc_exp);
	endtask
	task automatic cnt(input logic [5:0] fn, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] exp);
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, fn), a, 32'h0, 1'b0);
		chk({we, wa, wd}, {1'b1, 5'h02, exp});
	endtask
	task automatic test_counts();
		cnt(FN_LEAD_ZERO, 32'h0, 32'h20);
		cnt(FN_LEAD_ZERO, 32'h0001_0000, 32'h0F);
		cnt(FN_LEAD_ZERO, 32'h8000_0000, 32'h0);
		cnt(FN_LEAD_ONE, 32'hFFFF_FFFF, 32'h20);
		cnt(FN_LEAD_ONE, 32'hFFFE_0000, 32'h0F);
		cnt(FN_LEAD_ONE, 32'h7FFF_FFFF, 32'h0);
	endtask
	task automatic test_traps();
		issue(enc(OP_SPECIAL, 5'h07, SHAMT_ZERO, FN_MOVE_IF_ZERO), 32'h1, 32'h0, 1'b1);
		chk({trap, we, hnd}, 3'h4);
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, FN_SIGNED_MUL_ACC), 32'h5, 32'h5, 1'b1);
		chk({trap, busy}, 2'h2);
		repeat (2) @(negedge ref_clk);
		chk({hi, lo}, acc_exp);
		chk(rf.mem[7], 32'hA5A5_0007);
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, 6'h02), 32'h3, 32'h3, 1'b0);
		chk({rsv, we, busy}, 3'h4);
		issue(enc(OP_SECOND_GROUP, 5'h00, SHAMT_ZERO, 6'h3F), 32'h3, 32'h3, 1'b0);
		chk({rsv, we}, 2'h2);
	endtask
	task automatic test_done();
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		test_moves();
		test_mac();
		test_counts();
		test_traps();
		test_done();
	end
	initial begin
		#20000;
		err_count++;
		test_done();
	end
endmodule
